// ==== shared/nvm_pkg.sv ====
// Package: register map, control layout and memory command types
package nvm_pkg;
    timeunit 1ns;
    timeprecision 100ps;

    // Bus geometry
    localparam int AXI_ADDR_W = 16;
    localparam int AXI_DATA_W = 32;
    localparam int NVM_ADDR_W = 8;
    localparam int NVM_DATA_W = 8;

    // Register indices; byte address is four times the index
    localparam logic [11:0] CTRL_IDX   = 12'hFA6;
    localparam logic [11:0] UNLOCK_IDX = 12'hFA7;
    localparam logic [11:0] DATA_IDX   = 12'hFA8;
    localparam logic [11:0] ADDR_IDX   = 12'hFA9;
    localparam logic [11:0] STAT_IDX   = 12'hFAA;
    localparam logic [11:0] MASK_IDX   = 12'hFAB;

    // Control and status register field positions
    localparam int SPACE_BIT  = 7;
    localparam int CFG_BIT    = 6;
    localparam int ERASE_BIT  = 4;
    localparam int ABORT_BIT  = 3;
    localparam int PERMIT_BIT = 2;
    localparam int GO_BIT     = 1;
    localparam int RD_BIT     = 0;
    localparam int DONE_BIT   = 0;

    // Unlock keys, written in this order to the unlock port
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ  = 2'b10
    } state_type;

    typedef enum logic [1:0] {
        OP_READ  = 2'b00,
        OP_WRITE = 2'b01,
        OP_ERASE = 2'b10
    } op_type;

    typedef enum logic [1:0] {
        TGT_DATA = 2'b00,
        TGT_PROG = 2'b01,
        TGT_CFG  = 2'b10
    } target_type;

    // Control register, bit 7 down to bit 0
    typedef struct packed {
        logic space_select;
        logic config_space_select;
        logic unused5;
        logic erase_en;
        logic program_abort_flag;
        logic program_permit;
        logic go;
        logic rd;
    } ctrl_type;

    // Command towards the memory arrays
    typedef struct packed {
        logic                  start;
        op_type                op;
        target_type            target;
        logic [NVM_ADDR_W-1:0] addr;
        logic [NVM_DATA_W-1:0] wdata;
    } mem_cmd_type;

    function automatic logic [AXI_ADDR_W-1:0] reg_byte_addr(
        input logic [11:0] idx);
        reg_byte_addr = {2'b00, idx, 2'b00};
    endfunction

endpackage

// ==== verilog/nvm_access_control.sv ====
// Nonvolatile memory access control with AXI4-Lite register slave

// Operation
// - Unlock port always reads as zero
// - Space select one means program flash
// - Config select overrides space select
// - Erase enable turns go into block erase
// - Erase enable clears when erase finishes
// - Writes need permit bit; permit resets clear
// - Warm reset during write sets abort flag
// - Data and address registers reset to zero
// - Setting go starts write or erase
// - Go is set-only; hardware clears on completion
// - Write or erase completion sets done flag; software clears it
module nvm_access_control
    import nvm_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [AXI_ADDR_W-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [AXI_DATA_W-1:0] wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [AXI_ADDR_W-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [AXI_DATA_W-1:0]      rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    input  wire logic                  external_reset_pin,
    input  wire logic                  wdt_reset,
    output mem_cmd_type                mem_cmd,
    input  wire logic                  mem_done,
    input  wire logic [NVM_DATA_W-1:0] mem_rdata,
    output logic                       irq
);
    timeunit 1ns;
    timeprecision 100ps;

    logic                  awready_r;
    logic                  wready_r;
    logic                  bvalid_r;
    logic [1:0]            bresp_r;
    logic                  arready_r;
    logic                  rvalid_r;
    logic [AXI_DATA_W-1:0] rdata_r;
    logic [1:0]            rresp_r;
    logic                  aw_hold_r;
    logic                  w_hold_r;
    logic [AXI_ADDR_W-1:0] aw_addr_r;
    logic [7:0]            w_data_r;
    logic                  w_lane_r;
    ctrl_type              ctrl_r;
    ctrl_type              ctrl_nxt;
    state_type             state_r;
    state_type             state_nxt;
    logic [1:0]            unlock_r;
    logic [1:0]            unlock_nxt;
    logic [NVM_DATA_W-1:0] data_r;
    logic [NVM_ADDR_W-1:0] addr_r;
    logic [7:0]            stat_r;
    logic [7:0]            mask_r;
    logic [7:0]            stat_nxt;
    mem_cmd_type           mem_cmd_r;
    logic                  irq_r;

    // Bus handshakes
    wire aw_take = awvalid & awready_r;
    wire w_take  = wvalid & wready_r;
    wire ar_take = arvalid & arready_r;
    wire do_wr   = aw_hold_r & w_hold_r & ~bvalid_r;

    // Write decode; only byte lane 0 carries register data
    wire wr_ctrl   = do_wr & w_lane_r
                   & (aw_addr_r == reg_byte_addr(CTRL_IDX));
    wire wr_unlock = do_wr & w_lane_r
                   & (aw_addr_r == reg_byte_addr(UNLOCK_IDX));
    wire wr_data   = do_wr & w_lane_r
                   & (aw_addr_r == reg_byte_addr(DATA_IDX));
    wire wr_addr   = do_wr & w_lane_r
                   & (aw_addr_r == reg_byte_addr(ADDR_IDX));
    wire wr_stat   = do_wr & w_lane_r
                   & (aw_addr_r == reg_byte_addr(STAT_IDX));
    wire wr_mask   = do_wr & w_lane_r
                   & (aw_addr_r == reg_byte_addr(MASK_IDX));
    wire wr_mapped = (aw_addr_r == reg_byte_addr(CTRL_IDX))
                   | (aw_addr_r == reg_byte_addr(UNLOCK_IDX))
                   | (aw_addr_r == reg_byte_addr(DATA_IDX))
                   | (aw_addr_r == reg_byte_addr(ADDR_IDX))
                   | (aw_addr_r == reg_byte_addr(STAT_IDX))
                   | (aw_addr_r == reg_byte_addr(MASK_IDX));

    // Warm resets; power-on reset is rst itself
    wire warm    = external_reset_pin | wdt_reset;
    wire idle    = (state_r == ST_IDLE);
    wire wr_done = (state_r == ST_WRITE) & mem_done;
    wire rd_done = (state_r == ST_READ) & mem_done;

    // go refused without permit or unlock
    wire go_ok = wr_ctrl & w_data_r[GO_BIT] & w_data_r[PERMIT_BIT]
               & (unlock_r == 2'h2) & idle & ~warm;
    wire rd_ok = wr_ctrl & w_data_r[RD_BIT] & ~w_data_r[GO_BIT]
               & idle & ~warm;

    // space select picks flash or data; config wins
    wire target_type go_target = w_data_r[CFG_BIT] ? TGT_CFG :
                                 w_data_r[SPACE_BIT] ? TGT_PROG : TGT_DATA;
    // erase enable turns go into erase
    wire op_type go_op = w_data_r[ERASE_BIT] ? OP_ERASE : OP_WRITE;

    // Read mux; unlock port has no storage, reads zero
    wire [7:0] rd_byte =
        (araddr == reg_byte_addr(CTRL_IDX))   ? {ctrl_r[7:6], 1'b0,
                                                  ctrl_r[4:0]} :
        (araddr == reg_byte_addr(DATA_IDX))   ? data_r :
        (araddr == reg_byte_addr(ADDR_IDX))   ? addr_r :
        (araddr == reg_byte_addr(STAT_IDX))   ? stat_r :
        (araddr == reg_byte_addr(MASK_IDX))   ? mask_r : 8'h00;
    wire rd_mapped = (araddr == reg_byte_addr(CTRL_IDX))
                   | (araddr == reg_byte_addr(UNLOCK_IDX))
                   | (araddr == reg_byte_addr(DATA_IDX))
                   | (araddr == reg_byte_addr(ADDR_IDX))
                   | (araddr == reg_byte_addr(STAT_IDX))
                   | (araddr == reg_byte_addr(MASK_IDX));

    // Write channel holding; ready drops while a beat is held
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= 8'h00;
            w_lane_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            aw_hold_r <= (aw_hold_r | aw_take) & ~do_wr;
            w_hold_r  <= (w_hold_r | w_take) & ~do_wr;
            awready_r <= ~((aw_hold_r | aw_take) & ~do_wr);
            wready_r  <= ~((w_hold_r | w_take) & ~do_wr);
            if (aw_take)
                aw_addr_r <= awaddr;
            if (w_take) begin
                w_data_r <= wdata[7:0];
                w_lane_r <= wstrb[0];
            end
            if (do_wr) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bready)
                bvalid_r <= 1'b0;
        end
    end

    // Read channel; answer one cycle after the address is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= RESP_OKAY;
        end else begin
            arready_r <= ~(ar_take | (rvalid_r & ~rready));
            if (ar_take) begin
                rvalid_r <= 1'b1;
                rdata_r  <= {24'h000000, rd_byte};
                rresp_r  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (rready)
                rvalid_r <= 1'b0;
        end
    end

    // Unlock sequence tracker; a control write, a warm reset or a wrong key breaks it
    always_comb begin
        unlock_nxt = unlock_r;
        if (warm | wr_ctrl)
            unlock_nxt = 2'h0;
        else if (wr_unlock)
            unlock_nxt = (w_data_r == UNLOCK_KEY1) ? 2'h1 :
                         ((w_data_r == UNLOCK_KEY2) && (unlock_r == 2'h1))
                         ? 2'h2 : 2'h0;
    end

    // Control register and sequencer next state
    always_comb begin
        ctrl_nxt  = ctrl_r;
        state_nxt = state_r;
        if (warm) begin
            // space selects survive so software sees the target
            ctrl_nxt = CTRL_RST;
            ctrl_nxt.space_select        = ctrl_r.space_select;
            ctrl_nxt.config_space_select = ctrl_r.config_space_select;
            // write cut short by warm reset
            ctrl_nxt.program_abort_flag  =
                ctrl_r.program_abort_flag | (state_r == ST_WRITE);
            state_nxt = ST_IDLE;
        end else begin
            if (wr_ctrl) begin
                ctrl_nxt.space_select        = w_data_r[SPACE_BIT];
                ctrl_nxt.config_space_select = w_data_r[CFG_BIT];
                ctrl_nxt.erase_en            = w_data_r[ERASE_BIT];
                ctrl_nxt.program_abort_flag  = w_data_r[ABORT_BIT];
                ctrl_nxt.program_permit      = w_data_r[PERMIT_BIT];
            end
            if (go_ok) begin
                ctrl_nxt.go = 1'b1;
                state_nxt   = ST_WRITE;
            end else if (rd_ok) begin
                ctrl_nxt.rd = 1'b1;
                state_nxt   = ST_READ;
            end
            if (wr_done) begin
                ctrl_nxt.go = 1'b0;
                state_nxt   = ST_IDLE;
                // erase enable drops after an erase
                if (mem_cmd_r.op == OP_ERASE)
                    ctrl_nxt.erase_en = 1'b0;
            end
            if (rd_done) begin
                ctrl_nxt.rd = 1'b0;
                state_nxt   = ST_IDLE;
            end
        end
    end

    // done flag set wins over write-one clear
    assign stat_nxt = ((stat_r & ~({8{wr_stat}} & w_data_r))
                    | {7'h00, wr_done & ~warm}) & 8'h01;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r   <= CTRL_RST;
            state_r  <= ST_IDLE;
            unlock_r <= 2'h0;
            stat_r   <= STAT_RST;
            mask_r   <= MASK_RST;
            irq_r    <= 1'b0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            state_r  <= state_nxt;
            unlock_r <= unlock_nxt;
            stat_r   <= stat_nxt;
            if (wr_mask)
                mask_r <= w_data_r & 8'h01;
            irq_r    <= |(stat_nxt & (wr_mask ? w_data_r : mask_r));
        end
    end

    // data and address registers zero on any reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_r <= '0;
            addr_r <= '0;
        end else if (warm) begin
            data_r <= '0;
            addr_r <= '0;
        end else begin
            if (wr_data)
                data_r <= w_data_r;
            else if (rd_done)
                data_r <= mem_rdata;
            if (wr_addr)
                addr_r <= w_data_r;
        end
    end

    // Memory command; start is a one-cycle pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_cmd_r <= '0;
        end else begin
            mem_cmd_r.start <= go_ok | rd_ok;
            if (go_ok | rd_ok) begin
                mem_cmd_r.op     <= go_ok ? go_op : OP_READ;
                mem_cmd_r.target <= go_target;
                mem_cmd_r.addr   <= wr_addr ? w_data_r : addr_r;
                mem_cmd_r.wdata  <= data_r;
            end
        end
    end

    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;
    assign mem_cmd = mem_cmd_r;
    assign irq     = irq_r;

    property p_unlock_zero;
        @(posedge clk) disable iff (rst)
        ar_take && araddr == reg_byte_addr(UNLOCK_IDX)
            |=> rvalid_r && rdata_r == '0;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero)
        else $error("unlock port read not zero");

    property p_cfg_target;
        @(posedge clk) disable iff (rst)
        mem_cmd_r.start && ctrl_r.config_space_select
            |-> mem_cmd_r.target == TGT_CFG;
    endproperty
    a_cfg_target: assert property (p_cfg_target)
        else $error("config select ignored");

    property p_space_target;
        @(posedge clk) disable iff (rst)
        mem_cmd_r.start && !ctrl_r.config_space_select
            |-> mem_cmd_r.target == (ctrl_r.space_select ? TGT_PROG
                                                         : TGT_DATA);
    endproperty
    a_space_target: assert property (p_space_target)
        else $error("space select ignored");

    property p_erase_op;
        @(posedge clk) disable iff (rst)
        mem_cmd_r.start && state_r == ST_WRITE
            |-> mem_cmd_r.op == (ctrl_r.erase_en ? OP_ERASE : OP_WRITE);
    endproperty
    a_erase_op: assert property (p_erase_op)
        else $error("erase enable not honoured");

    property p_erase_clear;
        @(posedge clk) disable iff (rst)
        wr_done && !warm && mem_cmd_r.op == OP_ERASE
            |=> !ctrl_r.erase_en && !ctrl_r.go;
    endproperty
    a_erase_clear: assert property (p_erase_clear)
        else $error("erase enable kept after erase");

    property p_permit_start;
        @(posedge clk) disable iff (rst)
        $rose(state_r == ST_WRITE) |-> ctrl_r.program_permit
            && mem_cmd_r.start;
    endproperty
    a_permit_start: assert property (p_permit_start)
        else $error("write started without permit");

    property p_abort;
        @(posedge clk) disable iff (rst)
        warm && state_r == ST_WRITE
            |=> ctrl_r.program_abort_flag && state_r == ST_IDLE
                && !ctrl_r.program_permit;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort flag not set");

    property p_keep_space;
        @(posedge clk) disable iff (rst)
        warm |=> ctrl_r.space_select == $past(ctrl_r.space_select)
            && ctrl_r.config_space_select
               == $past(ctrl_r.config_space_select);
    endproperty
    a_keep_space: assert property (p_keep_space)
        else $error("space select lost on warm reset");

    property p_zero_regs;
        @(posedge clk) disable iff (rst)
        warm |=> data_r == '0 && addr_r == '0;
    endproperty
    a_zero_regs: assert property (p_zero_regs)
        else $error("data or address not zeroed");

    property p_go_start;
        @(posedge clk) disable iff (rst)
        go_ok |=> mem_cmd_r.start && ctrl_r.go ##1 !mem_cmd_r.start;
    endproperty
    a_go_start: assert property (p_go_start)
        else $error("go did not start a cycle");

    property p_go_hold;
        @(posedge clk) disable iff (rst)
        state_r == ST_WRITE && !mem_done && !warm |=> ctrl_r.go;
    endproperty
    a_go_hold: assert property (p_go_hold)
        else $error("go cleared before completion");

    property p_done_flag;
        @(posedge clk) disable iff (rst)
        wr_done && !warm |=> stat_r[DONE_BIT] && !ctrl_r.go;
    endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("done flag not set");

endmodule

// ==== verif/nvm_array_model.sv ====
// Memory array model: answers the most recent command after a programmable delay
module nvm_array_model
    import nvm_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire mem_cmd_type           mem_cmd,
    input  wire logic [7:0]            delay_cycles,
    output logic                       mem_done,
    output logic [NVM_DATA_W-1:0]      mem_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0]            count_r;
    logic                  busy_r;
    logic [NVM_ADDR_W-1:0] addr_r;
    logic [NVM_DATA_W-1:0] noise_r;

    // Read byte is valid only with the done pulse; churn otherwise
    assign mem_rdata = mem_done ? (addr_r ^ 8'h5A) : noise_r;

    // Busy timer; a new start restarts it, nothing is queued
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r  <= 8'h00;
            busy_r   <= 1'b0;
            mem_done <= 1'b0;
            addr_r   <= 8'h00;
            noise_r  <= 8'hC3;
        end else begin
            noise_r  <= noise_r + 8'h3B;
            mem_done <= 1'b0;
            if (mem_cmd.start) begin
                busy_r  <= 1'b1;
                count_r <= delay_cycles;
                addr_r  <= mem_cmd.addr;
            end else if (busy_r && count_r == 8'h00) begin
                busy_r   <= 1'b0;
                mem_done <= 1'b1;
            end else if (busy_r) begin
                count_r <= count_r - 8'h01;
            end
        end
    end
endmodule

// ==== verif/nvm_access_control_tb.sv ====
// Self-checking bench for the memory access control block
module nvm_access_control_tb
    import nvm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [7:0] ctrl;
        target_type tgt;
        op_type     op;
    } row_type;

    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    logic [AXI_ADDR_W-1:0] awaddr = '0;
    logic [AXI_ADDR_W-1:0] araddr = '0;
    logic [AXI_DATA_W-1:0] wdata = '0;
    logic [AXI_DATA_W-1:0] rdata;
    logic [AXI_DATA_W-1:0] rd_data;
    logic                  awvalid = 1'b0;
    logic                  wvalid = 1'b0;
    logic                  bready = 1'b0;
    logic                  arvalid = 1'b0;
    logic                  rready = 1'b0;
    logic [3:0]            wstrb = 4'hF;
    logic                  awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]            bresp, rresp, resp;
    logic                  external_reset_pin = 1'b0;
    logic                  wdt_reset = 1'b0;
    logic                  mem_done;
    logic [NVM_DATA_W-1:0] mem_rdata;
    logic [7:0]            delay_cycles = 8'h04;
    mem_cmd_type           mem_cmd;
    mem_cmd_type           last_cmd = '0;
    int                    starts = 0;
    int                    dones = 0;
    int                    dn;
    int                    err_count = 0;
    int                    comparisons = 0;
    row_type               rows [7] = '{
        '{8'h86, TGT_PROG, OP_WRITE}, '{8'h06, TGT_DATA, OP_WRITE},
        '{8'hC6, TGT_CFG, OP_WRITE}, '{8'h46, TGT_CFG, OP_WRITE},
        '{8'h96, TGT_PROG, OP_ERASE}, '{8'h81, TGT_PROG, OP_READ},
        '{8'h01, TGT_DATA, OP_READ}};

    nvm_access_control dut_u (
        .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .external_reset_pin(external_reset_pin), .wdt_reset(wdt_reset),
        .mem_cmd(mem_cmd), .mem_done(mem_done), .mem_rdata(mem_rdata),
        .irq(irq));

    nvm_array_model array_u (
        .clk(clk), .rst(rst), .mem_cmd(mem_cmd),
        .delay_cycles(delay_cycles), .mem_done(mem_done),
        .mem_rdata(mem_rdata));

    always #2.5 clk = ~clk;

    // Keep the last command and count array events
    always @(posedge clk) begin
        if (mem_cmd.start) begin
            last_cmd <= mem_cmd;
            starts   <= starts + 1;
        end
        if (mem_done)
            dones <= dones + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %0h want %0h", $time, got, exp);
        end
    endtask

    // Decisions are taken at the falling edge to stay clear of races
    task automatic axi_wr(input logic [11:0] idx, input logic [7:0] d);
        logic aw_go, w_go, b_go;
        @(posedge clk);
        awaddr  <= {2'b00, idx, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        b_go = 1'b0;
        while (!b_go) begin
            @(negedge clk);
            aw_go = awvalid && awready === 1'b1;
            w_go  = wvalid && wready === 1'b1;
            b_go  = bvalid === 1'b1;
            resp  = bresp;
            @(posedge clk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] idx);
        logic ar_go, r_go;
        @(posedge clk);
        araddr  <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        r_go = 1'b0;
        while (!r_go) begin
            @(negedge clk);
            ar_go   = arvalid && arready === 1'b1;
            r_go    = rvalid === 1'b1;
            rd_data = rdata;
            resp    = rresp;
            @(posedge clk);
            if (ar_go) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic wait_evt(input bit on_done, input int target);
        for (int n = 0; n < 300; n++) begin
            @(negedge clk);
            if ((on_done ? dones : starts) >= target)
                return;
        end
        err_count++;
        $display("MISMATCH t=%0t array event missing", $time);
    endtask

    task automatic start_op(input row_type r, input logic [7:0] a,
                            input logic [7:0] d);
        int n0;
        n0 = starts;
        axi_wr(DATA_IDX, d); // Reload data
        axi_wr(ADDR_IDX, a); // Reload address
        if (r.op != OP_READ) begin
            axi_wr(UNLOCK_IDX, UNLOCK_KEY1); // Key one
            axi_wr(UNLOCK_IDX, UNLOCK_KEY2); // Key two
        end
        axi_wr(CTRL_IDX, r.ctrl); // Launch
        wait_evt(1'b0, n0 + 1);
        chk(last_cmd.target, r.tgt); // Target
        chk(last_cmd.op, r.op); // Operation
        chk(last_cmd.addr, a); // Address
        if (r.op != OP_READ) chk(last_cmd.wdata, d); // Data
    endtask

    task automatic report_and_stop();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        axi_wr(MASK_IDX, 8'h01);
        // Ordinary operations, one per row
        foreach (rows[i]) begin
            dn = dones;
            start_op(rows[i], 8'h10 + i[7:0], 8'hA0 + i[7:0]);
            wait_evt(1'b1, dn + 1);
            axi_rd(CTRL_IDX);
            chk(rd_data, {24'h0, rows[i].ctrl & 8'hEC}); // Clears
            axi_rd(STAT_IDX);
            chk(rd_data, {31'h0, rows[i].op != OP_READ}); // Flag
            if (rows[i].op == OP_READ) begin
                axi_rd(DATA_IDX);
                chk(rd_data, {24'h0, (8'h10 + i[7:0]) ^ 8'h5A});
            end else begin
                @(negedge clk);
                chk(irq, 1'b1); // Irq raised
                axi_wr(MASK_IDX, 8'h00);
                @(negedge clk);
                chk(irq, 1'b0); // Irq masked
                axi_wr(MASK_IDX, 8'h01);
                axi_wr(STAT_IDX, 8'h01); // Software clear
                @(negedge clk);
                chk(irq, 1'b0); // Irq cleared
                axi_rd(STAT_IDX);
                chk(rd_data, 32'h0); // Cleared
            end
        end
        // Warm reset in mid-write, from each source in turn
        delay_cycles <= 8'h28;
        for (int i = 0; i < 2; i++) begin
            dn = dones;
            start_op('{8'hC6, TGT_CFG, OP_WRITE}, 8'h33, 8'h44);
            @(posedge clk);
            external_reset_pin <= (i == 0);
            wdt_reset          <= (i == 1);
            @(posedge clk);
            external_reset_pin <= 1'b0;
            wdt_reset          <= 1'b0;
            axi_rd(CTRL_IDX);
            chk(rd_data, 32'h0000_00C8); // Abort kept
            axi_rd(DATA_IDX);
            chk(rd_data, 32'h0); // Data zeroed
            axi_rd(ADDR_IDX);
            chk(rd_data, 32'h0); // Address zeroed
            wait_evt(1'b1, dn + 1);
            axi_rd(STAT_IDX);
            chk(rd_data, 32'h0); // No completion
            axi_wr(CTRL_IDX, 8'h00);
        end
        // A zero written to go while busy does not stop the write
        dn = dones;
        start_op('{8'h86, TGT_PROG, OP_WRITE}, 8'h21, 8'h65);
        axi_wr(CTRL_IDX, 8'h84);
        axi_rd(CTRL_IDX);
        chk(rd_data, 32'h0000_0086); // Set-only
        wait_evt(1'b1, dn + 1);
        axi_rd(CTRL_IDX);
        chk(rd_data, 32'h0000_0084); // Hardware clear
        axi_wr(STAT_IDX, 8'h01);
        // Go without the permit bit must not launch anything
        dn = starts;
        axi_wr(UNLOCK_IDX, UNLOCK_KEY1);
        axi_wr(UNLOCK_IDX, UNLOCK_KEY2);
        axi_wr(CTRL_IDX, 8'h02);
        repeat (4) @(posedge clk);
        chk(starts, dn); // No start
        axi_rd(CTRL_IDX);
        chk(rd_data, 32'h0); // Go refused
        // Unmapped place answers with an error
        axi_rd(12'h000);
        chk({rd_data[7:0], resp}, {8'h00, RESP_SLVERR});
        axi_wr(12'h001, 8'hFF);
        chk(resp, RESP_SLVERR);
        // Second power-on reset, then every register reads zero
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        axi_wr(UNLOCK_IDX, 8'hFF);
        for (int k = 0; k < 6; k++) begin
            axi_rd(CTRL_IDX + 12'(k));
            chk({rd_data, resp}, {32'h0, RESP_OKAY}); // Zeros
        end
        // Lane 0 strobe low: answered, but the mask keeps its value
        wstrb <= 4'h0;
        axi_wr(MASK_IDX, 8'h01);
        chk(resp, RESP_OKAY);
        wstrb <= 4'hF;
        axi_rd(MASK_IDX);
        chk(rd_data, 32'h0);
        report_and_stop();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
endmodule
